// ### core/caw_pkg.sv
// Purpose: Shared constants for the counter array watchdog and comparator clear block.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Bit positions follow the counter array control and mode registers.
package caw_pkg;

    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_MODE      = 8'h04;
    localparam logic [7:0] OFS_CNT_LO    = 8'h08;
    localparam logic [7:0] OFS_CNT_HI    = 8'h0c;
    localparam logic [7:0] OFS_M2_MODE   = 8'h10;
    localparam logic [7:0] OFS_WD_OFS    = 8'h14;
    localparam logic [7:0] OFS_WD_CMP    = 8'h18;
    localparam logic [7:0] OFS_CLR       = 8'h1c;

    localparam int BIT_RUN        = 6;
    localparam int BIT_FLAG2      = 2;
    localparam int BIT_IDLE_SUS   = 7;
    localparam int BIT_WD_EN      = 6;
    localparam int BIT_WD_LOCK    = 5;
    localparam int BIT_SEL_LO     = 1;
    localparam int BIT_CLR_POL    = 7;
    localparam int BIT_M2_MATCH   = 0;

    localparam logic       RST_WD_EN   = 1'b1;
    localparam logic [2:0] RST_SEL     = 3'h0;
    localparam logic [7:0] RST_CNT_LO  = 8'h00;
    localparam logic [7:0] RST_WD_OFS  = 8'h00;

    localparam logic [2:0] SEL_DIV12   = 3'h0;
    localparam logic [2:0] SEL_DIV4    = 3'h1;
    localparam logic [2:0] SEL_EXT     = 3'h2;
    localparam logic [2:0] SEL_SYS     = 3'h3;

    localparam logic [3:0] DIV12_LAST  = 4'hb;
    localparam int         SYS_PER_TICK_RESET = 12;
    localparam int         TICKS_PER_LOW_WRAP = 256;
    localparam int         DEFAULT_TIMEOUT_SYS = SYS_PER_TICK_RESET * TICKS_PER_LOW_WRAP;

    localparam int NUM_CHAN = 3;

endpackage : caw_pkg

// ### core/caw_sync2.sv
// Purpose: Two-stage synchroniser for a level from outside the clock domain.
// Assumes: Input may change at any time.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module caw_sync2 (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : caw_sync2

// ### core/caw_watchdog.sv
// Purpose: Watchdog on compare module 2 of the counter array, plus comparator clear of PWM outputs.
// Assumes: PWM waveforms, their mode flags and cycle start come from the neighbouring PWM logic.
// Notes: One clock; the counter advances on tick enables derived from CORE_CLK or taken from EXT_TICK.
`timescale 1ns/1ps

// What this block does
// - Module 2 becomes watchdog when enabled
// - Watchdog enabled after every reset
// - Counter forced running; run bit ignored
// - Counter byte writes ignored under watchdog
// - Clock select and idle suspend frozen
// - Module 2 software timer; mode writes ignored
// - Run bit reads as software wrote it
// - High byte write loads count plus offset
// - Low overflow with high match resets
// - Timeout is 256 times offset plus remainder
// - Writing flag one forces watchdog reset
// - Enable or lock enables; lock sticks
// - Clearing enable disables when unlocked
// - Reset defaults: divide by 12, zeros
// - Enabled PWM channel cleared by comparator
// - Disabled channel unaffected by comparator
// - Polarity zero clears on falling edge
// - Clearing level held keeps output low
// - Enable is mode bit 6, resets one
// - Event flag set by hardware, sticky
module caw_watchdog (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXT_TICK,
    input  wire logic        CPU_IDLE,
    input  wire logic        CMP_ASYNC,
    input  wire logic [2:0]  PWM_RAW,
    input  wire logic [2:0]  PWM_ACTIVE,
    input  wire logic        PWM_CYCLE_START,
    output logic [2:0]       CHANNEL_OUTPUT,
    output logic             WD_RESET_REQ
);

    typedef struct packed {
        logic        run;
        logic        flag2;
        logic        idle_sus;
        logic        wd_en;
        logic        wd_lock;
        logic [2:0]  sel;
        logic [7:0]  cnt_lo;
        logic [7:0]  cnt_hi;
        logic [7:0]  m2_mode;
        logic [7:0]  off_lo;
        logic [7:0]  cmp_hi;
        logic [2:0]  clr_en;
        logic        clr_pol;
        logic [3:0]  div;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        wd_rst;
        logic        cmp_prev;
        logic [2:0]  clr_act;
        logic [2:0]  chan_out;
    } caw_state_s;

    caw_state_s s_q;
    caw_state_s s_d;

    logic cmp_s;

    caw_sync2 u_cmp_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .d     (CMP_ASYNC),
        .q     (cmp_s)
    );

    logic       wd_on;
    logic       acc;
    logic       wr;
    logic       mapped;
    logic       tick;
    logic       running;
    logic       lo_wrap;
    logic       cnt_write;
    logic       force_rst;
    logic       timeout;
    logic       sw_match;
    logic       clr_edge;
    logic       clr_level;
    logic [7:0] wb;
    logic [7:0] rd;

    always_comb begin
        s_d       = s_q;
        wd_on     = s_q.wd_en | s_q.wd_lock;
        acc       = PSEL & PENABLE & s_q.pready;
        wr        = acc & PWRITE;
        wb        = PWDATA[7:0];
        mapped    = (PADDR[1:0] == 2'b00) && (PADDR <= caw_pkg::OFS_CLR);
        tick      = 1'b0;
        rd        = 8'h00;

        // Counter clock selection; the divider runs free so a change of selection takes effect at once.
        s_d.div = (s_q.div == caw_pkg::DIV12_LAST) ? 4'h0 : s_q.div + 4'h1;
        case (s_q.sel)
            caw_pkg::SEL_DIV4: tick = (s_q.div[1:0] == 2'b11);
            caw_pkg::SEL_EXT:  tick = EXT_TICK;
            caw_pkg::SEL_SYS:  tick = 1'b1;
            default:           tick = (s_q.div == caw_pkg::DIV12_LAST);
        endcase
        if (s_q.idle_sus && CPU_IDLE) begin
            tick = 1'b0;
        end

        // The watchdog forces the counter on without touching the run bit that software reads back.
        running   = s_q.run | wd_on;
        lo_wrap   = tick & running & (s_q.cnt_lo == 8'hff);
        timeout   = wd_on & lo_wrap & (s_q.cmp_hi == s_q.cnt_hi);
        force_rst = wd_on & wr & (PADDR == caw_pkg::OFS_CTRL) & wb[caw_pkg::BIT_FLAG2];
        sw_match  = ~wd_on & tick & running & s_q.m2_mode[caw_pkg::BIT_M2_MATCH]
                    & ({s_q.cmp_hi, s_q.off_lo} == {s_q.cnt_hi, s_q.cnt_lo});

        // Counter advance; software byte writes win only while the watchdog is off.
        cnt_write = wr & ~wd_on & ((PADDR == caw_pkg::OFS_CNT_LO) || (PADDR == caw_pkg::OFS_CNT_HI));
        if (tick && running) begin
            s_d.cnt_lo = s_q.cnt_lo + 8'h01;
            if (lo_wrap) begin
                s_d.cnt_hi = s_q.cnt_hi + 8'h01;
            end
        end

        if (wr) begin
            case (PADDR)
                caw_pkg::OFS_CTRL: begin
                    s_d.run = wb[caw_pkg::BIT_RUN];
                    if (!wb[caw_pkg::BIT_FLAG2]) begin
                        s_d.flag2 = 1'b0;
                    end else begin
                        s_d.flag2 = 1'b1;
                    end
                end
                caw_pkg::OFS_MODE: begin
                    if (!wd_on) begin
                        s_d.idle_sus = wb[caw_pkg::BIT_IDLE_SUS];
                        s_d.sel      = wb[caw_pkg::BIT_SEL_LO +: 3];
                    end
                    s_d.wd_en   = wb[caw_pkg::BIT_WD_EN];
                    s_d.wd_lock = s_q.wd_lock | wb[caw_pkg::BIT_WD_LOCK];
                end
                caw_pkg::OFS_CNT_LO: begin
                    if (cnt_write) begin
                        s_d.cnt_lo = wb;
                    end
                end
                caw_pkg::OFS_CNT_HI: begin
                    if (cnt_write) begin
                        s_d.cnt_hi = wb;
                    end
                end
                caw_pkg::OFS_M2_MODE: begin
                    if (!wd_on) begin
                        s_d.m2_mode = wb;
                    end
                end
                caw_pkg::OFS_WD_OFS: begin
                    s_d.off_lo = wb;
                end
                caw_pkg::OFS_WD_CMP: begin
                    if (wd_on) begin
                        s_d.cmp_hi = s_q.cnt_hi + s_q.off_lo;
                    end else begin
                        s_d.cmp_hi = wb;
                    end
                end
                caw_pkg::OFS_CLR: begin
                    s_d.clr_en  = wb[2:0];
                    s_d.clr_pol = wb[caw_pkg::BIT_CLR_POL];
                end
                default: begin
                end
            endcase
        end

        // Hardware set of the event flag wins over a software clear in the same cycle.
        if (sw_match) begin
            s_d.flag2 = 1'b1;
        end

        // Under the watchdog, module 2 runs as a software timer with its match flag withheld.
        if (wd_on) begin
            s_d.m2_mode[caw_pkg::BIT_M2_MATCH] = 1'b0;
        end

        s_d.wd_rst = timeout | force_rst;

        // Read mux; the enable bit reads back as enable or lock, so a locked watchdog always shows as on.
        case (PADDR)
            caw_pkg::OFS_CTRL:    rd = {1'b0, s_q.run, 3'b000, s_q.flag2, 2'b00};
            caw_pkg::OFS_MODE:    rd = {s_q.idle_sus, wd_on, s_q.wd_lock, 1'b0, s_q.sel, 1'b0};
            caw_pkg::OFS_CNT_LO:  rd = s_q.cnt_lo;
            caw_pkg::OFS_CNT_HI:  rd = s_q.cnt_hi;
            caw_pkg::OFS_M2_MODE: rd = s_q.m2_mode;
            caw_pkg::OFS_WD_OFS:  rd = s_q.off_lo;
            caw_pkg::OFS_WD_CMP:  rd = s_q.cmp_hi;
            caw_pkg::OFS_CLR:     rd = {s_q.clr_pol, 4'h0, s_q.clr_en};
            default:              rd = 8'h00;
        endcase

        // One wait state: ready rises in the second access cycle and the transfer completes there.
        s_d.pready  = PSEL & PENABLE & ~s_q.pready;
        s_d.pslverr = PSEL & PENABLE & ~s_q.pready & ~mapped;
        if (PSEL && PENABLE && !s_q.pready) begin
            s_d.prdata = (PWRITE || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd};
        end

        // Comparator clear; a clearing edge at a cycle start wins over the release.
        s_d.cmp_prev = cmp_s;
        clr_edge     = s_q.clr_pol ? (cmp_s & ~s_q.cmp_prev) : (~cmp_s & s_q.cmp_prev);
        clr_level    = s_q.clr_pol ? cmp_s : ~cmp_s;
        for (int i = 0; i < caw_pkg::NUM_CHAN; i++) begin
            if (PWM_CYCLE_START) begin
                s_d.clr_act[i] = clr_level;
            end
            if (clr_edge) begin
                s_d.clr_act[i] = 1'b1;
            end
            s_d.chan_out[i] = PWM_RAW[i] & ~(PWM_ACTIVE[i] & s_q.clr_en[i] & s_d.clr_act[i]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.wd_en    <= caw_pkg::RST_WD_EN;
            s_q.sel      <= caw_pkg::RST_SEL;
            s_q.cnt_lo   <= caw_pkg::RST_CNT_LO;
            s_q.off_lo   <= caw_pkg::RST_WD_OFS;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    assign PRDATA         = s_q.prdata;
    assign PREADY         = s_q.pready;
    assign PSLVERR        = s_q.pslverr;
    assign CHANNEL_OUTPUT = s_q.chan_out;
    assign WD_RESET_REQ   = s_q.wd_rst;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_reset_pulse_single: assert property (CE && WD_RESET_REQ |=> !WD_RESET_REQ)
        else $error("watchdog reset request longer than one cycle");
    a_timeout_cause: assert property (CE && timeout |=> WD_RESET_REQ)
        else $error("timeout without reset request");
    a_force_reset: assert property (CE && wd_on && wr && PADDR == caw_pkg::OFS_CTRL
                                    && PWDATA[caw_pkg::BIT_FLAG2] |=> WD_RESET_REQ)
        else $error("forced reset missing");
    a_no_reset_off: assert property (CE && !wd_on && !s_q.wd_en |=> !WD_RESET_REQ)
        else $error("reset request while watchdog off");
    a_refresh_load: assert property (CE && wd_on && wr && PADDR == caw_pkg::OFS_WD_CMP
                                     |=> s_q.cmp_hi == $past(s_q.cnt_hi) + $past(s_q.off_lo))
        else $error("refresh loaded wrong value");
    a_lock_sticks: assert property (s_q.wd_lock |=> s_q.wd_lock && wd_on)
        else $error("lock released before reset");
    a_sel_frozen: assert property (CE && wd_on |=> $stable(s_q.sel) && $stable(s_q.idle_sus))
        else $error("clock select changed under watchdog");
    a_count_runs: assert property (CE && wd_on && tick && s_q.cnt_lo != 8'hff
                                   |=> s_q.cnt_lo == $past(s_q.cnt_lo) + 8'h01)
        else $error("counter did not advance under watchdog");
    a_m2_frozen: assert property (CE && wd_on && wr && PADDR == caw_pkg::OFS_M2_MODE
                                  |=> s_q.m2_mode == $past(s_q.m2_mode))
        else $error("module 2 mode changed under watchdog");
    a_clear_output: assert property (CE && clr_edge && PWM_ACTIVE[0] && s_q.clr_en[0]
                                     |=> !CHANNEL_OUTPUT[0])
        else $error("channel not cleared by comparator");
    a_clear_bypass: assert property (CE && !s_q.clr_en[1] |=> CHANNEL_OUTPUT[1] == $past(PWM_RAW[1]))
        else $error("disabled channel affected by comparator");

    a_run_read_zero: assert property (CE && PSEL && PENABLE && !s_q.pready && !PWRITE && PADDR == caw_pkg::OFS_CTRL
                                      && !s_q.run |=> !PRDATA[caw_pkg::BIT_RUN])
        else $error("run bit read back as set");
    a_count_no_write: assert property (CE && wd_on && wr && PADDR == caw_pkg::OFS_CNT_HI && !lo_wrap
                                       |=> s_q.cnt_hi == $past(s_q.cnt_hi))
        else $error("count high byte written under watchdog");
    a_flag_sticky: assert property (CE && s_q.flag2 && !(wr && PADDR == caw_pkg::OFS_CTRL)
                                    |=> s_q.flag2)
        else $error("event flag cleared without software");
    a_level_hold: assert property (CE && PWM_CYCLE_START && clr_level && PWM_ACTIVE[0] && s_q.clr_en[0]
                                   |=> !CHANNEL_OUTPUT[0])
        else $error("channel released while comparator at clearing level");
    a_disable_unlocked: assert property (CE && wr && PADDR == caw_pkg::OFS_MODE && !s_q.wd_lock
                                         && !PWDATA[caw_pkg::BIT_WD_EN] && !PWDATA[caw_pkg::BIT_WD_LOCK]
                                         |=> !wd_on)
        else $error("watchdog stayed on after unlocked disable");

    // Covers for the main scenarios: timeout, refresh, forced reset and both clear paths.
    c_timeout: cover property (timeout);
    c_refresh: cover property (wd_on && wr && PADDR == caw_pkg::OFS_WD_CMP);
    c_force: cover property (force_rst);
    c_clear: cover property (clr_edge && |s_q.clr_en);
    c_level: cover property (PWM_CYCLE_START && clr_level && |s_q.clr_en);

endmodule : caw_watchdog

// ### verif/caw_rst_model.sv
// Purpose: Model of the system reset controller that counts watchdog reset requests.
// Assumes: Requests are one-cycle pulses in the core clock domain.
// Notes: The bench resets the block itself, so this model only records requests.
`timescale 1ns/1ps
module caw_rst_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic req,
    output int        n_req
);
    // A request is taken on any edge where it is high; a pulse spans one edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_req <= 0;
        end else if (req === 1'b1) begin
            n_req <= n_req + 1;
        end
    end
endmodule : caw_rst_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the counter array watchdog and comparator clear.
// Assumes: APB slave answers after one wait state; counter advances once per tick.
// Notes: Watchdog timeouts are measured in core clock cycles with a small tolerance.
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, idle = 0, cmp = 1, cst = 0, ext = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, wd_req;
    logic [2:0]  raw = 3'h7, act = 3'h7, chout;
    int          n_mismatch = 0, checks_done = 0, cyc = 0, n_req;
    logic [31:0] r;
    logic        e;
    always #12.5 clk = ~clk;
    caw_watchdog i_dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_TICK(ext), .CPU_IDLE(idle), .CMP_ASYNC(cmp), .PWM_RAW(raw),
        .PWM_ACTIVE(act), .PWM_CYCLE_START(cst), .CHANNEL_OUTPUT(chout), .WD_RESET_REQ(wd_req));
    caw_rst_model i_rst (.clk(clk), .rst_n(rst_n), .req(wd_req), .n_req(n_req));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // The ceiling allows all scenarios with ample margin.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input string nm, input logic [7:0] exp);
        apb(0, a, 8'h00);
        chk(nm, r, {24'h0, exp});
    endtask : rd
    task automatic do_reset();
        rst_n <= 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
    endtask : do_reset
    // Counts edges until a request, then checks the window and the single-cycle width.
    task automatic wait_req(input int lo, input int hi, input string nm);
        int n = 0;
        while (wd_req !== 1'b1 && n < hi + 5) begin
            @(posedge clk);
            n++;
        end
        chk(nm, {31'h0, (n >= lo && n <= hi)}, 32'h1);
        @(posedge clk);
        chk("req width", {31'h0, wd_req}, 32'h0);
    endtask : wait_req
    task automatic t_default();
        do_reset();
        wait_req(caw_pkg::DEFAULT_TIMEOUT_SYS, caw_pkg::DEFAULT_TIMEOUT_SYS + 2, "default timeout");
    endtask : t_default
    task automatic t_protect();
        logic [31:0] a;
        do_reset();
        rd(caw_pkg::OFS_MODE, "mode reset", 8'h40);
        apb(1, caw_pkg::OFS_MODE, 8'hc6);
        rd(caw_pkg::OFS_MODE, "mode frozen", 8'h40);
        apb(1, caw_pkg::OFS_M2_MODE, 8'h42);
        rd(caw_pkg::OFS_M2_MODE, "m2 mode", 8'h00);
        apb(1, caw_pkg::OFS_CNT_HI, 8'h77);
        rd(caw_pkg::OFS_CNT_HI, "count high", 8'h00);
        apb(1, caw_pkg::OFS_CTRL, 8'h00);
        rd(caw_pkg::OFS_CTRL, "run bit", 8'h00);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        a = r;
        repeat (60) @(posedge clk);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        chk("count runs", {31'h0, a != r}, 32'h1);
        apb(0, 8'h20, 8'h00);
        chk("unmapped data", r, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        apb(1, caw_pkg::OFS_MODE, 8'h00);
        rd(caw_pkg::OFS_MODE, "disable", 8'h00);
        apb(1, caw_pkg::OFS_MODE, 8'h20);
        apb(1, caw_pkg::OFS_MODE, 8'h00);
        rd(caw_pkg::OFS_MODE, "lock sticks", 8'h60);
        apb(1, caw_pkg::OFS_CTRL, 8'h04);
        wait_req(1, 1, "force reset");
    endtask : t_protect
    task automatic t_refresh();
        int k;
        do_reset();
        apb(1, caw_pkg::OFS_MODE, 8'h00);
        apb(1, caw_pkg::OFS_MODE, 8'h06);
        apb(1, caw_pkg::OFS_CNT_LO, 8'h00);
        apb(1, caw_pkg::OFS_WD_OFS, 8'h02);
        apb(1, caw_pkg::OFS_MODE, 8'h46);
        apb(1, caw_pkg::OFS_WD_CMP, 8'h00);
        k = n_req;
        repeat (3) begin
            repeat (400) @(posedge clk);
            apb(1, caw_pkg::OFS_WD_CMP, 8'h00);
        end
        chk("no request", n_req, k);
        // The last refresh lands 1215 ticks after enable, low byte 0xbf: 2*256 + 256 - 0xbf ticks remain.
        wait_req(576, 578, "offset timeout");
    endtask : t_refresh
    task automatic t_clear();
        do_reset();
        apb(1, caw_pkg::OFS_MODE, 8'h00);
        apb(1, caw_pkg::OFS_CLR, 8'h01);
        cmp <= 0;
        repeat (6) @(posedge clk);
        chk("pol0 fall", {29'h0, chout}, 32'h6);
        cst <= 1;
        @(posedge clk);
        cst <= 0;
        repeat (3) @(posedge clk);
        chk("level held", {29'h0, chout}, 32'h6);
        cmp <= 1;
        repeat (6) @(posedge clk);
        cst <= 1;
        @(posedge clk);
        cst <= 0;
        repeat (3) @(posedge clk);
        chk("released", {29'h0, chout}, 32'h7);
        apb(1, caw_pkg::OFS_CLR, 8'h82);
        cmp <= 0;
        repeat (6) @(posedge clk);
        chk("pol1 no fall", {29'h0, chout}, 32'h7);
        cmp <= 1;
        repeat (6) @(posedge clk);
        chk("pol1 rise", {29'h0, chout}, 32'h5);
        act <= 3'h5;
        raw <= 3'h3;
        repeat (2) @(posedge clk);
        chk("pwm mode off", {29'h0, chout}, 32'h3);
    endtask : t_clear
    // Idle suspend, its freeze under the watchdog, then the external tick and the divide-by-4 source with the watchdog off.
    task automatic t_modes();
        logic [31:0] a;
        apb(1, caw_pkg::OFS_CTRL, 8'h40);
        idle <= 1;
        apb(1, caw_pkg::OFS_MODE, 8'h86);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        a = r;
        repeat (20) @(posedge clk);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        chk("idle stops", r, a);
        apb(1, caw_pkg::OFS_MODE, 8'hc6);
        apb(1, caw_pkg::OFS_MODE, 8'h46);
        rd(caw_pkg::OFS_MODE, "idle frozen", 8'hc6);
        apb(1, caw_pkg::OFS_MODE, 8'h00);
        apb(1, caw_pkg::OFS_MODE, 8'h04);
        idle <= 0;
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        a = r;
        ext <= 1;
        repeat (5) @(posedge clk);
        ext <= 0;
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        chk("ext ticks", r, {24'h0, a[7:0] + 8'h05});
        apb(1, caw_pkg::OFS_MODE, 8'h02);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        a = r;
        repeat (40) @(posedge clk);
        apb(0, caw_pkg::OFS_CNT_LO, 8'h00);
        chk("div4 ticks", r, {24'h0, a[7:0] + 8'h0b});
    endtask : t_modes
    initial begin
        t_default();
        t_protect();
        t_refresh();
        t_clear();
        t_modes();
        stop_test();
    end
endmodule : tb
